/* File: trib_cfg.svh */
// Purpose: Constants for the touch reporter and idle blanking block
// Assumes: 200 MHz system clock
// Notes: Times are kept in their own unit; cycle counts derive from them
`ifndef TRIB_CFG_SVH
`define TRIB_CFG_SVH

`define TRIB_CLK_HZ 200000000
`define TRIB_SEC_CYCLES (`TRIB_CLK_HZ)
`define TRIB_REPORT_MS 10
`define TRIB_REPORT_CYCLES (`TRIB_CLK_HZ / 1000 * `TRIB_REPORT_MS)
`define TRIB_CNT_W 28

`define TRIB_SEC_PER_MIN 60
`define TRIB_T1_MIN 1
`define TRIB_T3_MIN 3
`define TRIB_T5_MIN 5
`define TRIB_T10_MIN 10
`define TRIB_MENU_IDLE_SEC 30

`define TRIB_HDR_TOUCH 8'h11
`define TRIB_HDR_RELEASE 8'h10
`define TRIB_BYTE_W 8
`define TRIB_COORD_W 10

`define TRIB_DEF_BLANK 3'h0
`define TRIB_DEF_ALARM 1'h1

`endif

/* File: trib_pkg.sv */
// Purpose: Types shared by the touch reporter and its byte framer
// Assumes: Constants come from trib_cfg.svh
// Notes: Reporter and framer state is carried in the structs below; the host model keeps its own
package trib_pkg;

    typedef enum logic [2:0] {
        TRIB_BLANK_OFF = 3'h0,
        TRIB_BLANK_1M = 3'h1,
        TRIB_BLANK_3M = 3'h2,
        TRIB_BLANK_5M = 3'h3,
        TRIB_BLANK_10M = 3'h4
    } trib_blank_type;

    typedef struct packed {
        trib_blank_type blank;
        logic alarm_en;
    } trib_settings_type;

    typedef struct packed {
        logic [9:0] x;
        logic [9:0] y;
    } trib_point_type;

    typedef struct packed {
        logic open;
        logic next_blank;
        logic toggle_alarm;
        logic apply;
        logic cancel;
        logic save;
    } trib_menu_cmd_type;

    typedef enum logic [2:0] {
        TRIB_TX_IDLE = 3'h0,
        TRIB_TX_REL = 3'h1,
        TRIB_TX_HDR = 3'h2,
        TRIB_TX_XH = 3'h3,
        TRIB_TX_XL = 3'h4,
        TRIB_TX_YH = 3'h5,
        TRIB_TX_YL = 3'h6
    } trib_tx_st_type;

    typedef struct packed {
        trib_tx_st_type st;
        trib_point_type pt;
        logic [7:0] data;
    } trib_tx_state_type;

    typedef struct packed {
        logic [2:0] tp_s;
        logic [2:0] lc_s;
        logic pressed;
        logic lamp_ok;
        logic [27:0] sec_cnt;
        logic blink;
        logic [9:0] idle_sec;
        logic light;
        logic burnout;
        logic green;
        logic red;
        logic menu_open;
        logic [4:0] menu_sec;
        trib_settings_type active;
        trib_settings_type edit;
        logic loaded;
        logic [27:0] rpt_cnt;
        logic sent;
        logic nv_we;
        trib_settings_type nv_data;
    } trib_main_state_type;

endpackage

/* File: trib_frame_tx.sv */
// Purpose: Serialises touched frames and release markers into bytes
// Assumes: Requests are taken only while idle
// Notes: Coordinates are latched at the header so a frame never tears
`timescale 1ns/1ps
`include "trib_cfg.svh"

module trib_frame_tx (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_touch,
    input wire logic req_release,
    input wire trib_pkg::trib_point_type point,
    output logic busy,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready
);

    trib_pkg::trib_tx_state_type s_reg;
    trib_pkg::trib_tx_state_type s_next;

    function automatic logic [7:0] trib_hi(input logic [9:0] c);
        return 8'(c >> `TRIB_BYTE_W);
    endfunction

    function automatic logic [7:0] trib_lo(input logic [9:0] c);
        return c[`TRIB_BYTE_W-1:0];
    endfunction

    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            trib_pkg::TRIB_TX_IDLE: begin
                if (req_touch) begin
                    s_next.st = trib_pkg::TRIB_TX_HDR;
                    s_next.pt = point;
                    s_next.data = `TRIB_HDR_TOUCH; // see RULE_11 see RULE_16
                end else if (req_release) begin
                    s_next.st = trib_pkg::TRIB_TX_REL;
                    s_next.data = `TRIB_HDR_RELEASE; // see RULE_15
                end
            end
            trib_pkg::TRIB_TX_REL: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_IDLE;
                end
            end
            trib_pkg::TRIB_TX_HDR: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_XH;
                    s_next.data = trib_hi(s_reg.pt.x); // see RULE_12
                end
            end
            trib_pkg::TRIB_TX_XH: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_XL;
                    s_next.data = trib_lo(s_reg.pt.x);
                end
            end
            trib_pkg::TRIB_TX_XL: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_YH;
                    s_next.data = trib_hi(s_reg.pt.y); // see RULE_12
                end
            end
            trib_pkg::TRIB_TX_YH: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_YL;
                    s_next.data = trib_lo(s_reg.pt.y);
                end
            end
            trib_pkg::TRIB_TX_YL: begin
                if (tx_ready) begin
                    s_next.st = trib_pkg::TRIB_TX_IDLE;
                end
            end
            default: begin
                s_next.st = trib_pkg::TRIB_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.st != trib_pkg::TRIB_TX_IDLE);
    assign tx_valid = busy;
    assign tx_byte = s_reg.data;

    property p_hdr_first;
        @(posedge clk) disable iff (!rst_b)
        (req_touch && !busy) |=> (tx_valid && tx_byte == `TRIB_HDR_TOUCH);
    endproperty
    a_hdr_first: assert property (p_hdr_first) // see RULE_11
        else $error("touched frame does not open with its header");

    property p_hi_lo_order;
        @(posedge clk) disable iff (!rst_b)
        (s_reg.st == trib_pkg::TRIB_TX_HDR && tx_ready) |=>
            (tx_byte == trib_hi(s_reg.pt.x) && tx_byte[7:2] == 6'h00);
    endproperty
    a_hi_lo_order: assert property (p_hi_lo_order) // see RULE_12
        else $error("x high byte not sent right after header");

    property p_release_alone;
        @(posedge clk) disable iff (!rst_b)
        (s_reg.st == trib_pkg::TRIB_TX_REL && tx_ready) |=> !tx_valid;
    endproperty
    a_release_alone: assert property (p_release_alone) // see RULE_15
        else $error("release marker followed by more bytes");

endmodule

/* File: trib_touch_report.sv */
// Purpose: Touch reporter with idle blanking, lamp alarm and settings menu
// Assumes: Touch point comes from a same-clock converter; pins are async
// Notes: Settings reload from nonvolatile storage once after power-up
// Behaviour
// RULE_01: Idle blanking timeout is 1, 3, 5, 10 minutes or off; off by default.
// RULE_02: With blanking on, no touch for the interval turns the backlight off.
// RULE_03: Lamp alarm, on by default, flags burnout; LED alternates or shows orange.
// RULE_04: During lamp burnout no touch report is sent to the host.
// RULE_05: Burnout is found from lamp current; some faults may go unseen.
// RULE_06: Apply commits the edit and closes; cancel drops it and closes.
// RULE_07: Save writes all adjusted settings to nonvolatile storage.
// RULE_08: Power-up loads the last saved settings; unsaved ones are lost.
// RULE_09: Menu closes after 30 s idle keeping the edit; cancel restores.
// RULE_10: Coordinates are 10 bits per axis, origin upper left.
// RULE_11: Touched frame is header 11h then two-byte X and two-byte Y.
// RULE_12: Each coordinate is sent high byte first, then low byte.
// RULE_13: A held touch keeps producing identical touched frames.
// RULE_14: Moving contact produces frames with the updated coordinates.
// RULE_15: On release one single 10h marker byte follows the last frame.
// RULE_16: Host splits the stream by header: 11h five bytes, 10h alone.
// RULE_17: Frame repetition interval is fixed and set by a parameter.
`timescale 1ns/1ps
`include "trib_cfg.svh"

module trib_touch_report #(
    parameter int unsigned SEC_CYCLES = `TRIB_SEC_CYCLES,
    parameter int unsigned REPORT_CYCLES = `TRIB_REPORT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic touch_pressed,
    input wire trib_pkg::trib_point_type touch_point,
    input wire logic lamp_current_ok,
    input wire logic led_style_orange,
    input wire trib_pkg::trib_menu_cmd_type menu_cmd,
    input wire logic nv_load_valid,
    input wire trib_pkg::trib_settings_type nv_load_data,
    output logic nv_save_strobe,
    output trib_pkg::trib_settings_type nv_save_data,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    output logic backlight_on,
    output logic led_green,
    output logic led_red,
    output logic lamp_burnout,
    output logic menu_active,
    output trib_pkg::trib_settings_type active_settings
);

    trib_pkg::trib_main_state_type s_reg;
    trib_pkg::trib_main_state_type s_next;
    logic tick;
    logic touch_eff;
    logic busy;
    logic req_touch;
    logic req_release;

    function automatic logic [9:0] trib_limit(
        input trib_pkg::trib_blank_type b);
        case (b)
            trib_pkg::TRIB_BLANK_1M:
                return 10'(`TRIB_T1_MIN * `TRIB_SEC_PER_MIN);
            trib_pkg::TRIB_BLANK_3M:
                return 10'(`TRIB_T3_MIN * `TRIB_SEC_PER_MIN);
            trib_pkg::TRIB_BLANK_5M:
                return 10'(`TRIB_T5_MIN * `TRIB_SEC_PER_MIN);
            trib_pkg::TRIB_BLANK_10M:
                return 10'(`TRIB_T10_MIN * `TRIB_SEC_PER_MIN);
            default:
                return '0;
        endcase
    endfunction

    function automatic trib_pkg::trib_blank_type trib_step(
        input trib_pkg::trib_blank_type b);
        case (b)
            trib_pkg::TRIB_BLANK_OFF: return trib_pkg::TRIB_BLANK_1M;
            trib_pkg::TRIB_BLANK_1M: return trib_pkg::TRIB_BLANK_3M;
            trib_pkg::TRIB_BLANK_3M: return trib_pkg::TRIB_BLANK_5M;
            trib_pkg::TRIB_BLANK_5M: return trib_pkg::TRIB_BLANK_10M;
            default: return trib_pkg::TRIB_BLANK_OFF;
        endcase
    endfunction

    assign tick = (s_reg.sec_cnt == `TRIB_CNT_W'(SEC_CYCLES - 1));
    // A lit lamp in burnout blocks touches; a release is still sent
    // so the host never sees a press that never ends
    assign touch_eff = s_reg.pressed && !s_reg.burnout; // see RULE_04
    assign req_touch = touch_eff && s_reg.rpt_cnt == '0 && !busy;
    assign req_release = !touch_eff && s_reg.sent && !busy; // see RULE_15

    always_comb begin
        s_next = s_reg;
        s_next.nv_we = 1'b0;
        // Second and third stage must agree before a pin change counts
        s_next.tp_s = {s_reg.tp_s[1:0], touch_pressed};
        s_next.lc_s = {s_reg.lc_s[1:0], lamp_current_ok};
        if (s_reg.tp_s[1] == s_reg.tp_s[2]) begin
            s_next.pressed = s_reg.tp_s[2];
        end
        if (s_reg.lc_s[1] == s_reg.lc_s[2]) begin
            s_next.lamp_ok = s_reg.lc_s[2]; // see RULE_05
        end

        s_next.sec_cnt = tick ? '0 : s_reg.sec_cnt + 1'b1;
        if (tick) begin
            s_next.blink = !s_reg.blink;
        end

        // Any contact, even during burnout, counts as panel use
        if (s_reg.pressed) begin
            s_next.idle_sec = '0;
        end else if (tick && !(&s_reg.idle_sec)) begin
            s_next.idle_sec = s_reg.idle_sec + 1'b1;
        end

        if (touch_eff) begin
            if (req_touch) begin
                s_next.rpt_cnt = `TRIB_CNT_W'(REPORT_CYCLES - 1); // see RULE_17
                s_next.sent = 1'b1; // see RULE_13 see RULE_14
            end else if (s_reg.rpt_cnt != '0) begin
                s_next.rpt_cnt = s_reg.rpt_cnt - 1'b1;
            end
        end else begin
            s_next.rpt_cnt = '0;
            if (req_release) begin
                s_next.sent = 1'b0;
            end
        end

        if (!s_reg.loaded && nv_load_valid) begin
            s_next.active = nv_load_data; // see RULE_08
            s_next.loaded = 1'b1;
        end

        if (!s_reg.menu_open) begin
            if (menu_cmd.open) begin
                s_next.menu_open = 1'b1;
                s_next.menu_sec = '0;
                s_next.edit = s_next.active;
            end
        end else if (menu_cmd.cancel) begin
            s_next.menu_open = 1'b0; // see RULE_06 see RULE_09
        end else if (menu_cmd.save) begin
            s_next.active = s_reg.edit;
            s_next.nv_we = 1'b1; // see RULE_07
            s_next.nv_data = s_reg.edit;
            s_next.menu_open = 1'b0;
        end else if (menu_cmd.apply) begin
            s_next.active = s_reg.edit; // see RULE_06
            s_next.menu_open = 1'b0;
        end else if (|menu_cmd) begin
            s_next.menu_sec = '0;
            if (menu_cmd.next_blank) begin
                s_next.edit.blank = trib_step(s_reg.edit.blank); // see RULE_01
            end
            if (menu_cmd.toggle_alarm) begin
                s_next.edit.alarm_en = !s_reg.edit.alarm_en;
            end
        end else if (tick) begin
            if (s_reg.menu_sec == 5'(`TRIB_MENU_IDLE_SEC - 1)) begin
                s_next.active = s_reg.edit; // see RULE_09
                s_next.menu_open = 1'b0;
            end else begin
                s_next.menu_sec = s_reg.menu_sec + 1'b1;
            end
        end

        s_next.light = !(s_next.active.blank != trib_pkg::TRIB_BLANK_OFF &&
            s_next.idle_sec >= trib_limit(s_next.active.blank)); // see RULE_02

        // Blanked lamp draws no current, so only a lit lamp is judged
        if (!s_next.active.alarm_en) begin
            s_next.burnout = 1'b0;
        end else if (s_reg.light && !s_reg.lamp_ok) begin
            s_next.burnout = 1'b1; // see RULE_03 see RULE_05
        end

        if (!s_next.burnout) begin
            s_next.green = 1'b1;
            s_next.red = 1'b0;
        end else if (led_style_orange) begin
            s_next.green = 1'b1; // see RULE_03
            s_next.red = 1'b1;
        end else begin
            s_next.green = s_next.blink;
            s_next.red = !s_next.blink;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
            s_reg.lamp_ok <= 1'b1;
            // Sync starts at the lamp-good level, else reset fakes a burnout
            s_reg.lc_s <= '1;
            s_reg.light <= 1'b1;
            s_reg.green <= 1'b1;
            s_reg.active.blank <= trib_pkg::trib_blank_type'(`TRIB_DEF_BLANK);
            s_reg.active.alarm_en <= `TRIB_DEF_ALARM; // see RULE_01 see RULE_03
        end else begin
            s_reg <= s_next;
        end
    end

    // Point is captured per frame, so motion shows in the next frame
    trib_frame_tx u_frame_tx (
        .clk(clk),
        .rst_b(rst_b),
        .req_touch(req_touch),
        .req_release(req_release),
        .point(touch_point), // see RULE_10
        .busy(busy),
        .tx_valid(tx_valid),
        .tx_byte(tx_byte),
        .tx_ready(tx_ready)
    );

    assign nv_save_strobe = s_reg.nv_we;
    assign nv_save_data = s_reg.nv_data;
    assign backlight_on = s_reg.light;
    assign led_green = s_reg.green;
    assign led_red = s_reg.red;
    assign lamp_burnout = s_reg.burnout;
    assign menu_active = s_reg.menu_open;
    assign active_settings = s_reg.active;

    property p_no_touch_burnout;
        @(posedge clk) disable iff (!rst_b)
        (lamp_burnout && !tx_valid) |=>
            !(tx_valid && tx_byte == `TRIB_HDR_TOUCH);
    endproperty
    a_no_touch_burnout: assert property (p_no_touch_burnout) // see RULE_04
        else $error("touched frame started during lamp burnout");

    property p_dark_needs_timeout;
        @(posedge clk) disable iff (!rst_b)
        $fell(backlight_on) |->
            (active_settings.blank != trib_pkg::TRIB_BLANK_OFF &&
             $past(s_reg.pressed, 2) == 1'b0);
    endproperty
    a_dark_needs_timeout: assert property (p_dark_needs_timeout) // see RULE_02
        else $error("backlight went off without an idle timeout");

    property p_orange;
        @(posedge clk) disable iff (!rst_b)
        (lamp_burnout && led_style_orange) ##1 lamp_burnout
            |-> (led_green && led_red);
    endproperty
    a_orange: assert property (p_orange) // see RULE_03
        else $error("burnout LED not orange");

    property p_cancel_keeps;
        @(posedge clk) disable iff (!rst_b)
        (menu_active && menu_cmd.cancel && !nv_load_valid) |=>
            (!menu_active && active_settings == $past(active_settings));
    endproperty
    a_cancel_keeps: assert property (p_cancel_keeps) // see RULE_06
        else $error("cancel changed the active setting");

    property p_save_writes;
        @(posedge clk) disable iff (!rst_b)
        (menu_active && menu_cmd.save && !menu_cmd.cancel) |=>
            (nv_save_strobe && nv_save_data == $past(s_reg.edit)) ##1
            !nv_save_strobe;
    endproperty
    a_save_writes: assert property (p_save_writes) // see RULE_07
        else $error("save did not write the edited settings once");

    property p_menu_timeout;
        @(posedge clk) disable iff (!rst_b)
        (menu_active && tick && menu_cmd == '0 &&
         s_reg.menu_sec == 5'(`TRIB_MENU_IDLE_SEC - 1)) |=>
            (!menu_active && active_settings == $past(s_reg.edit));
    endproperty
    a_menu_timeout: assert property (p_menu_timeout) // see RULE_09
        else $error("menu did not close keeping the edit after idle");

    property p_release_once;
        @(posedge clk) disable iff (!rst_b)
        req_release |=> (!s_reg.sent && tx_byte == `TRIB_HDR_RELEASE);
    endproperty
    a_release_once: assert property (p_release_once) // see RULE_15
        else $error("release marker not issued once");

endmodule

/* File: trib_host_model.sv */
// Purpose: Host side of the touch link; parses frames and markers
// Assumes: Byte handshake is tx_valid and tx_ready on the rising edge
// Notes: Stall makes the host take a byte only every other cycle
`timescale 1ns/1ps

module trib_host_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic stall,
    output logic tx_ready,
    output logic [9:0] last_x,
    output logic [9:0] last_y,
    output int n_frames,
    output int n_release,
    output int n_bad
);
    logic [7:0] held [0:2];
    int idx;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ready <= 1'b0;
            idx <= 0;
            n_frames <= 0;
            n_release <= 0;
            n_bad <= 0;
            last_x <= 10'h000;
            last_y <= 10'h000;
        end else begin
            tx_ready <= stall ? !tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                if (idx == 0) begin
                    // Split by header value; anything else is a framing slip
                    if (tx_byte == 8'h11)
                        idx <= 1;
                    else if (tx_byte == 8'h10)
                        n_release <= n_release + 1;
                    else
                        n_bad <= n_bad + 1;
                end else if (idx < 4) begin
                    held[idx - 1] <= tx_byte;
                    idx <= idx + 1;
                end else begin
                    // High byte first for each axis; upper bits must be zero
                    last_x <= {held[0][1:0], held[1]};
                    last_y <= {held[2][1:0], tx_byte};
                    if (held[0][7:2] != 6'h00 || held[2][7:2] != 6'h00)
                        n_bad <= n_bad + 1;
                    n_frames <= n_frames + 1;
                    idx <= 0;
                end
            end
        end
    end
endmodule

/* File: trib_touch_report_tb.sv */
// Purpose: Self-checking bench for the touch reporter
// Assumes: Short second and report counts keep the run brief
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module trib_touch_report_tb;
    localparam int SEC = 20;
    localparam int RPT = 30;
    localparam logic [5:0] C_OPEN = 6'h20;
    localparam logic [5:0] C_NEXT = 6'h10;
    localparam logic [5:0] C_TOG = 6'h08;
    localparam logic [5:0] C_APPLY = 6'h04;
    localparam logic [5:0] C_CANCEL = 6'h02;
    localparam logic [5:0] C_SAVE = 6'h01;
    logic clk, rst_b, touch_pressed, lamp_current_ok, led_style_orange;
    trib_pkg::trib_point_type touch_point;
    trib_pkg::trib_menu_cmd_type menu_cmd;
    logic nv_load_valid, nv_save_strobe, tx_valid, tx_ready, stall;
    trib_pkg::trib_settings_type nv_load_data, nv_save_data, active_settings;
    logic [7:0] tx_byte;
    logic backlight_on, led_green, led_red, lamp_burnout, menu_active;
    logic [9:0] last_x, last_y;
    int n_frames, n_release, n_bad, miscompares, n_compared, n_saves;
    int t, f0, r0, g, r;
    logic [2:0] b;

    trib_touch_report #(.SEC_CYCLES(SEC), .REPORT_CYCLES(RPT))
        u_trib_touch_report (.clk(clk), .rst_b(rst_b),
        .touch_pressed(touch_pressed), .touch_point(touch_point),
        .lamp_current_ok(lamp_current_ok),
        .led_style_orange(led_style_orange), .menu_cmd(menu_cmd),
        .nv_load_valid(nv_load_valid), .nv_load_data(nv_load_data),
        .nv_save_strobe(nv_save_strobe), .nv_save_data(nv_save_data),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .backlight_on(backlight_on), .led_green(led_green),
        .led_red(led_red), .lamp_burnout(lamp_burnout),
        .menu_active(menu_active), .active_settings(active_settings));

    trib_host_model u_trib_host_model (.clk(clk), .rst_b(rst_b),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .stall(stall),
        .tx_ready(tx_ready), .last_x(last_x), .last_y(last_y),
        .n_frames(n_frames), .n_release(n_release), .n_bad(n_bad));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end

    always @(posedge clk) begin
        if (nv_save_strobe === 1'b1)
            n_saves <= n_saves + 1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %0h expected %0h", $time, seen,
                exp);
        end
    endtask

    task automatic cmd(input logic [5:0] c);
        menu_cmd = c;
        step(1);
        menu_cmd = 6'h00;
        step(1);
    endtask

    task automatic nv_load(input logic [3:0] d);
        nv_load_data = d;
        nv_load_valid = 1'b1;
        step(1);
        nv_load_valid = 1'b0;
        step(1);
    endtask

    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        rst_b = 1'b0;
        touch_pressed = 1'b0;
        touch_point = 20'h00000;
        lamp_current_ok = 1'b1;
        led_style_orange = 1'b0;
        menu_cmd = 6'h00;
        nv_load_valid = 1'b0;
        nv_load_data = 4'h0;
        stall = 1'b0;
        n_saves = 0;
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        step(1);
        check(active_settings, 4'h1);
        check({backlight_on, led_green, led_red, lamp_burnout}, 4'hC);
        check(menu_active, 1'b0);
        nv_load(4'h3);
        check(active_settings, 4'h3);
        nv_load(4'h9);
        check(active_settings, 4'h3);
        // One minute of no touch must darken the backlight
        t = 0;
        while (backlight_on === 1'b1 && t < 2000) begin
            step(1);
            t++;
        end
        check(t >= 1140 && t <= 1240, 1'b1);
        touch_point = {10'd23, 10'd500};
        touch_pressed = 1'b1;
        step(20);
        check(backlight_on, 1'b1);
        check({last_x, last_y}, {10'd23, 10'd500});
        f0 = n_frames;
        stall = 1'b1;
        step(4 * RPT);
        check(n_frames - f0 >= 3 && n_frames - f0 <= 5, 1'b1);
        check({last_x, last_y}, {10'd23, 10'd500});
        touch_point = {10'h3FF, 10'h000};
        step(2 * RPT);
        check({last_x, last_y}, {10'h3FF, 10'h000});
        r0 = n_release;
        touch_pressed = 1'b0;
        step(2 * RPT);
        f0 = n_frames;
        step(3 * RPT);
        check(n_release - r0, 1);
        check(n_frames - f0, 0);
        check(n_bad, 0);
        stall = 1'b0;
        // Step through every blanking code, then end with it disabled
        b = 3'h1;
        repeat (4) begin
            cmd(C_OPEN);
            check(menu_active, 1'b1);
            cmd(C_NEXT);
            cmd(C_APPLY);
            b = (b == 3'h4) ? 3'h0 : b + 3'h1;
            check(menu_active, 1'b0);
            check(active_settings, {b, 1'b1});
        end
        cmd(C_OPEN);
        cmd(C_NEXT);
        cmd(C_TOG);
        cmd(C_CANCEL);
        check({menu_active, active_settings}, 5'h01);
        cmd(C_OPEN);
        cmd(C_NEXT);
        cmd(C_APPLY);
        f0 = n_saves;
        cmd(C_OPEN);
        cmd(C_SAVE);
        step(2);
        check(n_saves - f0, 1);
        check(nv_save_data, 4'h3);
        cmd(C_CANCEL);
        cmd(C_OPEN);
        cmd(C_NEXT);
        step(30 * SEC - 40);
        check({menu_active, active_settings}, 5'h13);
        step(80);
        check({menu_active, active_settings}, 5'h05);
        check(nv_save_data, 4'h3);
        touch_pressed = 1'b1;
        step(10);
        touch_pressed = 1'b0;
        step(2 * RPT);
        lamp_current_ok = 1'b0;
        step(8);
        check(lamp_burnout, 1'b1);
        g = 0;
        r = 0;
        repeat (3 * SEC) begin
            step(1);
            g += (led_green === 1'b1 && led_red === 1'b0);
            r += (led_red === 1'b1 && led_green === 1'b0);
        end
        check(g > 0 && r > 0, 1'b1);
        led_style_orange = 1'b1;
        step(2);
        check({led_green, led_red}, 2'h3);
        f0 = n_frames;
        touch_pressed = 1'b1;
        step(3 * RPT);
        check(n_frames - f0, 0);
        touch_pressed = 1'b0;
        step(RPT);
        cmd(C_OPEN);
        cmd(C_TOG);
        cmd(C_APPLY);
        check({lamp_burnout, active_settings}, 5'h04);
        lamp_current_ok = 1'b1;
        step(4);
        complete_run();
    end
endmodule
